// File: dead_timer.sv
`timescale 1ns/1ps
module dead_timer #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    // Control
    input  wire logic         load_i,
    input  wire logic         clear_i,
    input  wire logic [W-1:0] count_i,
    // Status
    output logic              expired_o
);

    logic [W-1:0] cnt_q;
    logic         armed_q;

    // Load wins over clear so a new interval is never lost
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q   <= '0;
            armed_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (load_i)
            begin
                cnt_q   <= count_i;
                armed_q <= 1'b1;
            end
            else if (clear_i)
                armed_q <= 1'b0;
            else if (armed_q && cnt_q != '0)
                cnt_q <= cnt_q - W'(1);
        end
    end

    // Level until cleared or reloaded
    assign expired_o = armed_q && (cnt_q == '0);

endmodule : dead_timer

// File: fbps_pkg.sv
package fbps_pkg;

    // Clock and fixed timing
    localparam int CLK_PERIOD_PS    = 8000;
    localparam int FIXED_DEAD_PS    = 30000;
    // Least time, so round up to whole cycles
    localparam int FIXED_DEAD_CYC   = (FIXED_DEAD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Default widths
    localparam int CNT_W_DEF        = 12;
    localparam int DT_W_DEF         = 8;

    // Reset values
    localparam logic       SIDE_RST   = 1'b1;
    localparam logic       DISCH_RST  = 1'b1;
    localparam logic [1:0] RECT_RST   = 2'h0;
    localparam logic [3:0] BRIDGE_RST = 4'h0;

    // One switching half-period of the bridge
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_POWER = 2'b10,
        ST_FREE  = 2'b11
    } phase_state_t;

    // Comparator results, all synchronous to mclk_i
    typedef struct packed {
        logic ramp_above_ctrl;
        logic ramp_above_ss;
        logic ss_above_offset;
        logic ss_above_2v;
        logic comp_current_high;
        logic rectifier_softstart_level_high;
        logic line_enable_sense;
        logic bias_good;
        logic ref_good;
    } sense_t;

    // Bridge gate drive
    typedef struct packed {
        logic high_side_a_out;
        logic high_side_b_out;
        logic low_side_a_out;
        logic low_side_b_out;
    } bridge_t;

    // Rectifier control
    typedef struct packed {
        logic rectifier_a_ctrl;
        logic rectifier_b_ctrl;
    } rect_t;

endpackage : fbps_pkg

// File: fbps_props.sv
`timescale 1ns/1ps
module fbps_props
    import fbps_pkg::*;
#(
    parameter int CNT_W = 12,
    parameter int DT_W  = 8
) (
    // Clock, reset and inputs
    input wire logic              mclk_i,
    input wire logic              rst_n_i,
    input wire logic              ce_i,
    input wire logic              osc_clk_i,
    input wire fbps_pkg::sense_t  sense_i,
    input wire logic [DT_W-1:0]   dead_time_one_set_i,
    input wire logic [DT_W-1:0]   dead_time_two_set_i,
    // Outputs under watch
    input wire fbps_pkg::bridge_t bridge_o,
    input wire fbps_pkg::rect_t   rect_o,
    input wire logic              ss_discharge_o,
    input wire logic              ssr_discharge_o
);
    logic        osc_q;
    logic [15:0] since_q;
    logic [15:0] per_q;
    logic [15:0] off_q;
    logic        rise;
    logic        run;
    logic        on;
    // Oscillator edge and rectifier enable as the sequencer sees them
    assign rise = osc_clk_i & ~osc_q;
    assign run  = sense_i.rectifier_softstart_level_high & ~ssr_discharge_o;
    assign on   = |bridge_o;
    // Cycles since the last oscillator rise and length of the last period
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            osc_q   <= 1'b0;
            since_q <= 16'h0;
            per_q   <= 16'h0;
            off_q   <= 16'h0;
        end
        else
        begin
            osc_q   <= osc_clk_i;
            since_q <= rise ? 16'h0 : since_q + 16'h1;
            per_q   <= rise ? since_q + 16'h1 : per_q;
            off_q   <= on ? 16'h0 : off_q + 16'h1;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    property p_diag_pair;
        bridge_o.high_side_a_out == bridge_o.low_side_b_out && bridge_o.high_side_b_out == bridge_o.low_side_a_out;
    endproperty
    a_diag_pair: assert property (p_diag_pair) else $error("bridge diagonal split");
    // Dead-timer one plus register stage, one cycle of latitude on the launch edge
    property p_lead_dead;
        $rose(on) |-> since_q >= 16'(dead_time_one_set_i) + 16'h1 && since_q <= 16'(dead_time_one_set_i) + 16'h2;
    endproperty
    a_lead_dead: assert property (p_lead_dead) else $error("bridge start off dead time");
    property p_duty_cap;
        $fell(on) |-> since_q + 16'h2 <= per_q;
    endproperty
    a_duty_cap: assert property (p_duty_cap) else $error("bridge on beyond limit");
    property p_trip_end;
        on && (sense_i.ramp_above_ctrl || sense_i.ramp_above_ss || !sense_i.ss_above_offset) |=> !on;
    endproperty
    a_trip_end: assert property (p_trip_end) else $error("bridge missed trip");
    property p_a_sync;
        bridge_o.high_side_a_out |-> !rect_o.rectifier_b_ctrl
            && (!$rose(bridge_o.high_side_a_out) || !$past(run) || rect_o.rectifier_a_ctrl);
    endproperty
    a_a_sync: assert property (p_a_sync) else $error("rectifier wrong in phase a");
    property p_b_excl;
        bridge_o.high_side_b_out |-> !rect_o.rectifier_a_ctrl;
    endproperty
    a_b_excl: assert property (p_b_excl) else $error("rectifier a on in phase b");
    property p_rect_off;
        !run |=> rect_o == 2'h0;
    endproperty
    a_rect_off: assert property (p_rect_off) else $error("rectifier on while held");
    property p_ss_dis;
        1'b1 |=> ss_discharge_o == $past(!(sense_i.line_enable_sense && sense_i.bias_good && sense_i.ref_good));
    endproperty
    a_ss_dis: assert property (p_ss_dis) else $error("soft-start discharge wrong");
    property p_ssr_set;
        ss_discharge_o |=> ssr_discharge_o;
    endproperty
    a_ssr_set: assert property (p_ssr_set) else $error("rectifier discharge not set");
    property p_ssr_clr;
        !ss_discharge_o && sense_i.ss_above_2v && !sense_i.comp_current_high |=> !ssr_discharge_o;
    endproperty
    a_ssr_clr: assert property (p_ssr_clr) else $error("rectifier discharge not released");
    property p_ssr_hold;
        ssr_discharge_o && sense_i.comp_current_high |=> ssr_discharge_o;
    endproperty
    a_ssr_hold: assert property (p_ssr_hold) else $error("rectifier discharge released early");
    property p_handover;
        rise && !ss_discharge_o && sense_i.ss_above_offset && run && rect_o == 2'h3 |-> ##[1:2] $onehot(rect_o);
    endproperty
    a_handover: assert property (p_handover) else $error("rectifier handover missing");
    // Freewheel overlap may not start before dead-time two has run out
    property p_free_dead;
        $rose(rect_o == 2'h3) |-> off_q >= 16'(dead_time_two_set_i) + 16'h1;
    endproperty
    a_free_dead: assert property (p_free_dead) else $error("freewheel inside dead time two");
    c_pulse_a: cover property ($rose(bridge_o.high_side_a_out));
    c_pulse_b: cover property ($rose(bridge_o.high_side_b_out));
    c_freewheel: cover property (rect_o == 2'h3);
    c_ssr_release: cover property ($fell(ssr_discharge_o));
endmodule : fbps_props

// File: full_bridge_phase_sequencer.sv
// Functional notes
// - First phase drives high side A with low side B as one diagonal.
// - After each diagonal all four bridge outputs stay off until next phase.
// - Alternate phase drives high side B with low side A, then all off.
// - A fixed 30 ns dead-time is always inserted, independent of oscillator rate.
// - Per-phase on-time is capped at oscillator period minus dead-time one and the fixed dead-time.
// - With dead-time one zero, duty stays just under half from fixed dead-time.
// - With no loop current the ramp never trips, so duty runs at maximum.
// - During diagonal A, rectifier A is on and rectifier B is off.
// - During diagonal B, rectifier B is on and rectifier A is off.
// - In freewheel both rectifier outputs are on together.
// - Rectifier B drops dead-time one before diagonal A turns on.
// - Two dead-times are set independently; only dead-time one limits duty.
// - Soft-start node held discharged until line, bias and reference are good.
// - Pulse ends when ramp passes lower of soft-start and loop levels.
// - Soft-start held low forces zero duty; release restarts normally.
// - Rectifier soft-start node released once soft-start is high and loop current low.
// - Rectifier soft-start begins only after its level crosses threshold.
// - Both rectifier outputs stay off throughout primary soft-start.
// - Rectifier soft-start widens the leading edge of each rectifier pulse.
// - Both rectifiers pulse in freewheel; at clock edge out-of-phase one drops.
// - In soft-start the in-phase rectifier drops with the bridge pulse end.
// - Rectifier soft-start node held low keeps both rectifiers off.
`timescale 1ns/1ps
module full_bridge_phase_sequencer
    import fbps_pkg::*;
#(
    parameter int CNT_W = fbps_pkg::CNT_W_DEF,
    parameter int DT_W  = fbps_pkg::DT_W_DEF
) (
    // Clock, reset and enable
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    // Internal oscillator clock and comparators
    input  wire logic              osc_clk_i,
    input  wire fbps_pkg::sense_t  sense_i,
    // Dead-time settings in mclk cycles
    input  wire logic [DT_W-1:0]   dead_time_one_set_i,
    input  wire logic [DT_W-1:0]   dead_time_two_set_i,
    // Gate drive and rectifier control
    output fbps_pkg::bridge_t      bridge_o,
    output fbps_pkg::rect_t        rect_o,
    // Soft-start node discharge switches
    output logic                   ss_discharge_o,
    output logic                   ssr_discharge_o
);

    import fbps_pkg::*;

    // One bit wider than the count so a short period saturates instead of wrapping
    localparam logic [CNT_W:0]   FIXED_DEAD = (CNT_W+1)'(FIXED_DEAD_CYC);
    localparam logic [CNT_W-1:0] WIDTH_STEP = CNT_W'(1);

    // Sequencer state
    phase_state_t     state_q;
    logic             side_q;
    logic [CNT_W-1:0] on_cnt_q;
    logic [CNT_W-1:0] on_limit_q;
    logic [CNT_W-1:0] width_q;

    // Results of the period meter and the two dead-timers
    logic             osc_rise;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] elapsed;
    logic             t1_expired;
    logic             t2_expired;

    // Per-cycle decisions
    logic             start_ok;
    logic             lead_done;
    logic             trip;
    logic             pwr_end;
    logic             rect_run;
    logic             rect_full;
    logic [CNT_W:0]   limit_raw;
    logic [CNT_W-1:0] limit_now;
    logic [CNT_W-1:0] remaining;
    logic             both_on;
    bridge_t          drive_on;

    // Oscillator edge and period measurement
    osc_period_meter #(
        .W          (CNT_W)
    ) u_meter (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .osc_clk_i  (osc_clk_i),
        .osc_rise_o (osc_rise),
        .period_o   (period),
        .elapsed_o  (elapsed)
    );

    // Dead-time one: rectifier turn-off to bridge turn-on
    dead_timer #(
        .W          (DT_W)
    ) u_dead_one (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .load_i     (start_ok),
        .clear_i    (lead_done),
        .count_i    (dead_time_one_set_i),
        .expired_o  (t1_expired)
    );

    // Dead-time two: bridge turn-off to freewheel rectifier turn-on
    dead_timer #(
        .W          (DT_W)
    ) u_dead_two (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .load_i     (pwr_end),
        .clear_i    (osc_rise),
        .count_i    (dead_time_two_set_i),
        .expired_o  (t2_expired)
    );

    // Phase decisions from the comparators
    always_comb
    begin
        // Comparator bits are already in this clock domain, no sync stage
        start_ok  = osc_rise && !ss_discharge_o && sense_i.ss_above_offset;
        lead_done = (state_q == ST_LEAD) && t1_expired;
        // Lower of soft-start and loop level; soft-start only counts above offset
        trip      = sense_i.ramp_above_ctrl || sense_i.ramp_above_ss || !sense_i.ss_above_offset;
        pwr_end   = (state_q == ST_POWER) && (trip || (on_cnt_q + CNT_W'(1) >= on_limit_q));
        // Only dead-time one and the fixed dead-time shorten the on-time
        limit_raw = {1'b0, period} - (CNT_W+1)'(dead_time_one_set_i) - FIXED_DEAD;
        limit_now = limit_raw[CNT_W] ? '0 : limit_raw[CNT_W-1:0];
        // Rectifiers act only with their node released and above threshold
        rect_run  = sense_i.rectifier_softstart_level_high && !ssr_discharge_o;
        // Full width ends rectifier soft-start until rect_run drops and the width resets
        rect_full = (width_q >= period);
        // Cycles to the next rise; zero if the oscillator runs late
        remaining = (elapsed >= period) ? '0 : period - elapsed;
        // Leading edge of the freewheel pulse moves earlier as width grows
        both_on   = t2_expired && (width_q >= remaining);
        // Diagonal pair owned by the current side
        drive_on  = BRIDGE_RST;
        if (!side_q)
        begin
            drive_on.high_side_a_out = 1'b1;
            drive_on.low_side_b_out  = 1'b1;
        end
        else
        begin
            drive_on.high_side_b_out = 1'b1;
            drive_on.low_side_a_out  = 1'b1;
        end
    end

    // Primary soft-start node discharge
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            ss_discharge_o <= DISCH_RST;
        else if (ce_i)
            // Any one fault discharges at once; filtering is left to the comparators
            ss_discharge_o <= !(sense_i.line_enable_sense && sense_i.bias_good && sense_i.ref_good);
    end

    // Rectifier soft-start node discharge; release is held until primary restarts
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            ssr_discharge_o <= DISCH_RST;
        else if (ce_i)
        begin
            // Latched release, so loop current noise cannot restart the rectifiers
            if (ss_discharge_o)
                ssr_discharge_o <= 1'b1;
            else if (sense_i.ss_above_2v && !sense_i.comp_current_high)
                ssr_discharge_o <= 1'b0;
        end
    end

    // Bridge phase state machine and gate outputs
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state_q    <= ST_IDLE;
            side_q     <= SIDE_RST;
            on_cnt_q   <= '0;
            on_limit_q <= '0;
            bridge_o   <= BRIDGE_RST;
        end
        else if (ce_i)
        begin
            if (osc_rise)
            begin
                // A new oscillator edge always ends the old half-period
                bridge_o <= BRIDGE_RST;
                if (start_ok)
                begin
                    side_q     <= !side_q;
                    on_limit_q <= limit_now;
                    state_q    <= ST_LEAD;
                end
                else
                    state_q <= ST_IDLE;
            end
            else
            begin
                // Between rises the half-period walks lead, power, freewheel
                case (state_q)
                    ST_LEAD:
                    begin
                        if (lead_done)
                        begin
                            on_cnt_q <= '0;
                            // A zero limit skips the pulse and never loads dead-time two for the freewheel
                            if (on_limit_q == '0)
                                state_q <= ST_FREE;
                            else
                            begin
                                bridge_o <= drive_on;
                                state_q  <= ST_POWER;
                            end
                        end
                    end
                    ST_POWER:
                    begin
                        // Trip or limit ends the pulse; counting runs only while on
                        if (pwr_end)
                        begin
                            bridge_o <= BRIDGE_RST;
                            state_q  <= ST_FREE;
                        end
                        else
                            on_cnt_q <= on_cnt_q + CNT_W'(1);
                    end
                    // Gates stay off until the next oscillator rise
                    ST_FREE:
                        bridge_o <= BRIDGE_RST;
                    ST_IDLE:
                        bridge_o <= BRIDGE_RST;
                    default:
                    begin
                        bridge_o <= BRIDGE_RST;
                        state_q  <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Leading-edge width grows one cycle per oscillator period until full
    // Limitation: the rate is fixed and does not follow the node's ramp slope
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            width_q <= '0;
        else if (ce_i)
        begin
            if (!rect_run)
                width_q <= '0;
            else if (osc_rise && !rect_full)
                width_q <= width_q + WIDTH_STEP;
        end
    end

    // Rectifier control outputs
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            rect_o <= RECT_RST;
        else if (ce_i)
        begin
            if (!rect_run)
                rect_o <= RECT_RST;
            else if (start_ok)
            begin
                // Out-of-phase rectifier drops a full dead-time one before the bridge
                if (side_q)
                    rect_o.rectifier_b_ctrl <= 1'b0;
                else
                    rect_o.rectifier_a_ctrl <= 1'b0;
            end
            // A refused rise leaves neither rectifier conducting
            else if (osc_rise)
                rect_o <= RECT_RST;
            // In soft-start the in-phase rectifier ends with the bridge pulse
            else if (pwr_end && !rect_full)
                rect_o <= RECT_RST;
            // Freewheel waits for dead-time two and the moving leading edge
            else if (state_q == ST_FREE && both_on)
                rect_o <= 2'h3;
            else if (lead_done && on_limit_q != '0)
            begin
                // In-phase rectifier conducts with its diagonal
                rect_o.rectifier_a_ctrl <= !side_q;
                rect_o.rectifier_b_ctrl <= side_q;
            end
        end
    end

endmodule : full_bridge_phase_sequencer

// File: gate_driver_model.sv
`timescale 1ns/1ps
module gate_driver_model
    import fbps_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // Gate commands from the sequencer
    input  wire fbps_pkg::bridge_t bridge_i,
    // Pulse report and leg short flag
    output logic                   done_o,
    output logic                   side_o,
    output logic [15:0]            width_o,
    output logic                   shoot_o
);
    logic [15:0] cnt_q;
    // Counts gate on-time; a real leg shorts the rail if both its switches conduct
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q   <= 16'h0;
            done_o  <= 1'b0;
            side_o  <= 1'b0;
            width_o <= 16'h0;
            shoot_o <= 1'b0;
        end
        else
        begin
            cnt_q   <= (|bridge_i) ? cnt_q + 16'h1 : 16'h0;
            side_o  <= (|bridge_i) ? bridge_i.high_side_a_out : side_o;
            done_o  <= (cnt_q != 16'h0) && !(|bridge_i);
            width_o <= cnt_q;
            shoot_o <= (bridge_i.high_side_a_out & bridge_i.low_side_a_out)
                     | (bridge_i.high_side_b_out & bridge_i.low_side_b_out);
        end
    end
endmodule : gate_driver_model

// File: osc_period_meter.sv
`timescale 1ns/1ps
module osc_period_meter #(
    parameter int W = 12
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    // Internal oscillator clock, sampled
    input  wire logic         osc_clk_i,
    // Results
    output logic              osc_rise_o,
    output logic [W-1:0]      period_o,
    output logic [W-1:0]      elapsed_o
);

    logic osc_prev_q;

    assign osc_rise_o = osc_clk_i && !osc_prev_q;

    // Elapsed count saturates so a stalled oscillator cannot wrap
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            osc_prev_q <= 1'b0;
            period_o   <= '0;
            elapsed_o  <= '0;
        end
        else if (ce_i)
        begin
            osc_prev_q <= osc_clk_i;
            if (osc_rise_o)
            begin
                period_o  <= elapsed_o + W'(1);
                elapsed_o <= '0;
            end
            else if (elapsed_o != '1)
                elapsed_o <= elapsed_o + W'(1);
        end
    end

endmodule : osc_period_meter

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import fbps_pkg::*;
    localparam int P = 40;
    typedef struct packed { logic side; logic [15:0] width; } pulse_t;
    logic       mclk_i;
    logic       rst_n_i;
    logic       ce_i;
    logic       osc_clk_i;
    sense_t     sense_i;
    logic [7:0] dead_time_one_set_i;
    logic [7:0] dead_time_two_set_i;
    bridge_t    bridge_o;
    rect_t      rect_o;
    logic       ss_discharge_o;
    logic       ssr_discharge_o;
    logic       done;
    logic       side;
    logic       shoot;
    logic [15:0] width;
    logic       side_n;
    logic       offs;
    logic [7:0] t1s[4];
    pulse_t     exp_q[$];
    int         errors;
    int         samples_checked;

    // Free-running clock
    initial mclk_i = 1'b0;
    always #4 mclk_i = ~mclk_i;

    full_bridge_phase_sequencer #(.CNT_W(12), .DT_W(8)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .osc_clk_i(osc_clk_i), .sense_i(sense_i), .dead_time_one_set_i(dead_time_one_set_i),
        .dead_time_two_set_i(dead_time_two_set_i), .bridge_o(bridge_o), .rect_o(rect_o),
        .ss_discharge_o(ss_discharge_o), .ssr_discharge_o(ssr_discharge_o));
    gate_driver_model u_drv (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bridge_i(bridge_o), .done_o(done),
        .side_o(side), .width_o(width), .shoot_o(shoot));

    task chk_lvl(input string what, input logic [3:0] exp, input logic [3:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_lvl

    task chk_pulse(input pulse_t exp, input pulse_t got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED pulse expected %h seen %h", exp, got);
        end
    endtask : chk_pulse

    task results;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    // One oscillator period; how picks the trip source, k on-cycles before it (0 = none)
    task half(input logic [7:0] t1, input int k, input int how, input logic acc, input logic fw);
        int   on_n;
        logic trip;
        on_n = 0;
        dead_time_one_set_i = t1;
        dead_time_two_set_i = 8'($urandom_range(3, 0));
        if (acc)
        begin
            exp_q.push_back(pulse_t'{side_n, 16'(k != 0 ? k : P - int'(t1) - FIXED_DEAD_CYC)});
            side_n = !side_n;
        end
        for (int i = 0; i < P; i++)
        begin
            trip = (k != 0) && (on_n >= k);
            osc_clk_i = (i < 4);
            sense_i.ramp_above_ctrl = trip && how == 0;
            sense_i.ramp_above_ss = trip && how == 1;
            sense_i.ss_above_offset = offs && !(trip && how == 2);
            @(posedge mclk_i);
            #1;
            if (|bridge_o)
                on_n++;
        end
        if (fw)
            chk_lvl("freewheel", 4'h3, {2'h0, rect_o});
    endtask : half

    // Each finished bridge pulse is matched against the oldest expectation
    always @(posedge mclk_i)
    begin
        if (rst_n_i && shoot)
            chk_lvl("leg short", 4'h0, 4'h1);
        if (rst_n_i && done && exp_q.size() == 0)
            chk_lvl("unexpected pulse", 4'h0, 4'h1);
        else if (rst_n_i && done)
            chk_pulse(exp_q.pop_front(), {side, width});
    end

    // Watchdog, well beyond the planned run
    initial
    begin
        repeat (8000) @(posedge mclk_i);
        errors++;
        results;
    end

    initial
    begin
        void'($urandom(76799));
        errors = 0;
        samples_checked = 0;
        side_n = 1'b1;
        offs = 1'b1;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        osc_clk_i = 1'b0;
        sense_i = '0;
        dead_time_one_set_i = 8'h0;
        dead_time_two_set_i = 8'h0;
        t1s = '{8'h0, 8'h3, 8'h9, 8'($urandom_range(12, 1))};
        repeat (6) @(posedge mclk_i);
        #1;
        rst_n_i = 1'b1;
        chk_lvl("reset bridge", 4'h0, bridge_o);
        chk_lvl("reset discharge", 4'h3, {2'h0, ss_discharge_o, ssr_discharge_o});
        repeat (2) half(8'h0, 0, 0, 1'b0, 1'b0);
        sense_i.line_enable_sense = 1'b1;
        sense_i.bias_good = 1'b1;
        sense_i.ref_good = 1'b1;
        // Release inside a refused period, so the measured period stays whole
        half(8'h0, 0, 0, 1'b0, 1'b0);
        chk_lvl("soft-start release", 4'h1, {2'h0, ss_discharge_o, ssr_discharge_o});
        $display("test startup done");
        foreach (t1s[j])
            repeat (2) half(t1s[j], 0, 0, 1'b1, 1'b0);
        $display("test max duty done");
        for (int h = 0; h < 3; h++)
            half(8'h2, 3 + h + int'($urandom_range(6, 0)), h, 1'b1, 1'b0);
        offs = 1'b0;
        repeat (2) half(8'h2, 0, 0, 1'b0, 1'b0);
        offs = 1'b1;
        half(8'h2, 0, 0, 1'b1, 1'b0);
        $display("test trip and shutdown done");
        sense_i.ss_above_2v = 1'b1;
        sense_i.comp_current_high = 1'b1;
        half(8'h2, 0, 0, 1'b1, 1'b0);
        chk_lvl("rectifier hold", 4'h1, {2'h0, ss_discharge_o, ssr_discharge_o});
        sense_i.comp_current_high = 1'b0;
        sense_i.rectifier_softstart_level_high = 1'b1;
        half(8'h2, 0, 0, 1'b1, 1'b0);
        chk_lvl("rectifier release", 4'h0, {2'h0, ss_discharge_o, ssr_discharge_o});
        half(8'h2, 0, 0, 1'b1, 1'b0);
        chk_lvl("rectifier soft end", 4'h0, {2'h0, rect_o});
        repeat (43) half(8'h2, 20, 0, 1'b1, 1'b1);
        repeat (3) half(8'h2, 4, 0, 1'b1, 1'b1);
        sense_i.rectifier_softstart_level_high = 1'b0;
        half(8'h2, 0, 0, 1'b1, 1'b0);
        chk_lvl("rectifier off", 4'h0, {2'h0, rect_o});
        repeat (4) @(posedge mclk_i);
        #1;
        chk_lvl("pending pulses", 4'h0, 4'(exp_q.size()));
        $display("test rectifier done");
        results;
    end
endmodule : tb_top

bind full_bridge_phase_sequencer fbps_props #(.CNT_W(CNT_W), .DT_W(DT_W)) u_props (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .ce_i(ce_i), .osc_clk_i(osc_clk_i), .sense_i(sense_i),
    .dead_time_one_set_i(dead_time_one_set_i), .dead_time_two_set_i(dead_time_two_set_i),
    .bridge_o(bridge_o), .rect_o(rect_o), .ss_discharge_o(ss_discharge_o), .ssr_discharge_o(ssr_discharge_o));
